// [rtl/mhc_pkg.sv]
package mhc_pkg;
  // register offsets on the plain register port (byte addresses)
  localparam logic [7:0] MHC_P1_MSR_OFF   = 8'h00;  // port 1 modem status, read only
  localparam logic [7:0] MHC_P1_MCR_OFF   = 8'h04;  // port 1 modem control
  localparam logic [7:0] MHC_P1_IER_OFF   = 8'h08;  // port 1 interrupt enable
  localparam logic [7:0] MHC_P2_MSR_OFF   = 8'h10;  // port 2 modem status, read only
  localparam logic [7:0] MHC_P2_MCR_OFF   = 8'h14;  // port 2 modem control
  localparam logic [7:0] MHC_P2_IER_OFF   = 8'h18;  // port 2 interrupt enable
  localparam logic [7:0] MHC_IRQ_STS_OFF  = 8'h20;  // sticky event status, read only
  localparam logic [7:0] MHC_IRQ_CLR_OFF  = 8'h24;  // write one to clear status
  localparam logic [7:0] MHC_IRQ_EN_OFF   = 8'h28;  // event enable
  localparam logic [7:0] MHC_PORT_STRIDE  = 8'h10;  // address step between the two ports
  // modem control field positions
  localparam int MHC_MCR_DTR_BIT  = 0;
  localparam int MHC_MCR_RTS_BIT  = 1;
  localparam int MHC_MCR_LOOP_BIT = 4;
  // interrupt enable field position
  localparam int MHC_IER_MS_BIT   = 3;
  // reset values
  localparam logic [7:0] MHC_MCR_RST  = 8'h00;
  localparam logic [7:0] MHC_IER_RST  = 8'h00;
  localparam logic [1:0] MHC_IRQ_RST  = 2'h0;
  localparam logic [7:0] MHC_RD_ZERO  = 8'h00;

  // four modem inputs of one port, all active low as they arrive
  typedef struct packed {
    logic carrier_n;  // status bit 7 / change bit 3
    logic ring_n;     // status bit 6 / change bit 2
    logic set_rdy_n;  // status bit 5 / change bit 1
    logic clr_send_n; // status bit 4 / change bit 0
  } mhc_modem_in_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mhc_req_t;
endpackage

// [rtl/mhc_top.sv]
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mhc_top (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire mhc_pkg::mhc_req_t      reg_req_i,
  output logic [7:0]                  reg_rdata_o,
  input  wire mhc_pkg::mhc_modem_in_t port1_modem_i,
  input  wire mhc_pkg::mhc_modem_in_t port2_modem_i,
  output logic                        port1_req_send_out_n_o,
  output logic                        port1_term_ready_out_n_o,
  output logic                        port2_req_send_out_n_o,
  output logic                        port2_term_ready_out_n_o,
  input  wire logic                   port2_uart_tx_i,
  input  wire logic                   port2_serial_in_i,
  output logic                        port2_serial_out_o,
  output logic                        port2_uart_rx_o,
  output logic                        port_irq_o,
  output logic                        irq_o
);
  import mhc_pkg::*;

  // per-port state kept in arrays indexed by port number
  logic [3:0]    prev_in_r   [2];   // input levels as last sampled
  logic [3:0]    delta_r     [2];   // change flags, bits 0..3 of status
  logic [7:0]    mcr_r       [2];   // modem control registers
  logic [7:0]    ier_r       [2];   // interrupt enable registers
  logic [1:0]    port_int_r;        // per-port modem-status interrupt latch
  logic [1:0]    irq_sts_r;         // sticky event status
  logic [1:0]    irq_en_r;          // event enable
  logic [7:0]    rdata_r;           // registered read data
  logic          rts_n_r     [2];   // registered request-to-send pins
  logic          dtr_n_r     [2];   // registered terminal-ready pins
  logic          ser_out_r;         // registered port 2 line output
  logic          ser_in_r;          // registered port 2 line input
  logic          irq_r;             // registered system interrupt

  // current inputs of both ports
  wire logic [3:0] cur_in [2];
  assign cur_in[0] = port1_modem_i;
  assign cur_in[1] = port2_modem_i;

  // register decode, one status read strobe per port
  wire logic [1:0] msr_rd;
  wire logic [1:0] mcr_wr;
  wire logic [1:0] ier_wr;
  wire logic       clr_wr;
  wire logic       en_wr;
  assign msr_rd[0] = reg_req_i.rd && reg_req_i.addr == MHC_P1_MSR_OFF;
  assign msr_rd[1] = reg_req_i.rd && reg_req_i.addr == MHC_P2_MSR_OFF;
  assign mcr_wr[0] = reg_req_i.wr && reg_req_i.addr == MHC_P1_MCR_OFF;
  assign mcr_wr[1] = reg_req_i.wr && reg_req_i.addr == MHC_P2_MCR_OFF;
  assign ier_wr[0] = reg_req_i.wr && reg_req_i.addr == MHC_P1_IER_OFF;
  assign ier_wr[1] = reg_req_i.wr && reg_req_i.addr == MHC_P2_IER_OFF;
  assign clr_wr    = reg_req_i.wr && reg_req_i.addr == MHC_IRQ_CLR_OFF;
  assign en_wr     = reg_req_i.wr && reg_req_i.addr == MHC_IRQ_EN_OFF;

  // status byte: upper nibble is the complement of the pins, lower the change flags
  function automatic logic [7:0] msr_val(input logic [3:0] pins, input logic [3:0] delta);
    msr_val = {~pins, delta};
  endfunction

  // output pin level from control byte: set bit drives low, loop forces high
  function automatic logic pin_n(input logic [7:0] modem_control_reg, input int bitpos);
    pin_n = modem_control_reg[MHC_MCR_LOOP_BIT] ? 1'b1 : ~modem_control_reg[bitpos];
  endfunction

  // per-port change detection and interrupt request
  wire logic [3:0] rise   [2];  // low-to-high since last sample
  wire logic [3:0] nxt_dl [2];  // next change flags
  wire logic [1:0] any_chg;     // any of the four inputs toggled
  wire logic [1:0] port_int_nxt;
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      assign rise[p]    = cur_in[p] & ~prev_in_r[p];
      // a rising edge in the read cycle survives the clear
      assign nxt_dl[p]  = (msr_rd[p] ? 4'h0 : delta_r[p]) | rise[p];
      assign any_chg[p] = |(cur_in[p] ^ prev_in_r[p]);
      // interrupt latched on any change, cleared by the status read, set wins
      assign port_int_nxt[p] = ier_r[p][MHC_IER_MS_BIT] &&
                               ((port_int_r[p] && !msr_rd[p]) || any_chg[p]);
    end
  endgenerate

  // read mux, unmapped addresses read as zero
  wire logic [7:0] rd_mux;
  assign rd_mux = (reg_req_i.addr == MHC_P1_MSR_OFF)  ? msr_val(cur_in[0], delta_r[0]) :
                  (reg_req_i.addr == MHC_P2_MSR_OFF)  ? msr_val(cur_in[1], delta_r[1]) :
                  (reg_req_i.addr == MHC_P1_MCR_OFF)  ? mcr_r[0] :
                  (reg_req_i.addr == MHC_P2_MCR_OFF)  ? mcr_r[1] :
                  (reg_req_i.addr == MHC_P1_IER_OFF)  ? ier_r[0] :
                  (reg_req_i.addr == MHC_P2_IER_OFF)  ? ier_r[1] :
                  (reg_req_i.addr == MHC_IRQ_STS_OFF) ? {6'h00, irq_sts_r} :
                  (reg_req_i.addr == MHC_IRQ_EN_OFF)  ? {6'h00, irq_en_r} : MHC_RD_ZERO;

  // sticky status: new port interrupt rises set, clear wins never over a set
  wire logic [1:0] int_rise;
  wire logic [1:0] sts_nxt;
  assign int_rise = port_int_nxt & ~port_int_r;
  assign sts_nxt  = (irq_sts_r & ~(clr_wr ? reg_req_i.wdata[1:0] : 2'h0)) | int_rise;

  // per-port registers
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (sys_rst_i) begin
        prev_in_r[i] <= 4'hf;
        delta_r[i]   <= 4'h0;
        mcr_r[i]     <= MHC_MCR_RST;
        ier_r[i]     <= MHC_IER_RST;
        rts_n_r[i]   <= 1'b1;
        dtr_n_r[i]   <= 1'b1;
      end else begin
        prev_in_r[i] <= cur_in[i];
        delta_r[i]   <= nxt_dl[i];
        if (mcr_wr[i]) begin
          mcr_r[i] <= reg_req_i.wdata;
        end
        if (ier_wr[i]) begin
          ier_r[i] <= reg_req_i.wdata;
        end
        // outputs follow the control register the cycle after it changes
        rts_n_r[i] <= pin_n(mcr_r[i], MHC_MCR_RTS_BIT);
        dtr_n_r[i] <= pin_n(mcr_r[i], MHC_MCR_DTR_BIT);
      end
    end
  end

  // interrupt and read path registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port_int_r <= 2'h0;
      irq_sts_r  <= MHC_IRQ_RST;
      irq_en_r   <= MHC_IRQ_RST;
      rdata_r    <= MHC_RD_ZERO;
      irq_r      <= 1'b0;
    end else begin
      port_int_r <= port_int_nxt;
      irq_sts_r  <= sts_nxt;
      if (en_wr) begin
        irq_en_r <= reg_req_i.wdata[1:0];
      end
      rdata_r <= reg_req_i.rd ? rd_mux : MHC_RD_ZERO;
      irq_r   <= |(sts_nxt & (en_wr ? reg_req_i.wdata[1:0] : irq_en_r));
    end
  end

  // port 2 line pins registered straight through; no clear-to-send gating on transmit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ser_out_r <= 1'b1;
      ser_in_r  <= 1'b1;
    end else begin
      ser_out_r <= port2_uart_tx_i;
      ser_in_r  <= port2_serial_in_i;
    end
  end

  assign reg_rdata_o              = rdata_r;
  assign port1_req_send_out_n_o   = rts_n_r[0];
  assign port1_term_ready_out_n_o = dtr_n_r[0];
  assign port2_req_send_out_n_o   = rts_n_r[1];
  assign port2_term_ready_out_n_o = dtr_n_r[1];
  assign port2_serial_out_o       = ser_out_r;
  assign port2_uart_rx_o          = ser_in_r;
  assign port_irq_o               = port_int_r[1];
  assign irq_o                    = irq_r;

  // assertions: each watches what the block drives, never the bench
  // status levels: a read shows the complement of the pins seen in the read cycle
  // port 1 set-ready lands inverted in bit 5
  status_bit5_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    reg_req_i.rd && reg_req_i.addr == MHC_P1_MSR_OFF |=> reg_rdata_o[5] == !$past(port1_modem_i.set_rdy_n))
    else $error("status bit 5 not the inverse of set-ready");
  // port 1 clear-to-send lands inverted in bit 4
  // the pin is only reported, here, in status bit 4, change bit 0 and through the port interrupt
  status_bit4_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    msr_rd[0] |=> reg_rdata_o[4] == !$past(port1_modem_i.clr_send_n))
    else $error("status bit 4 not the inverse of clear-to-send");
  // port 1 ring lands inverted in bit 6
  status_bit6_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    msr_rd[0] |=> reg_rdata_o[6] == !$past(port1_modem_i.ring_n))
    else $error("status bit 6 not the inverse of ring");
  // port 1 carrier lands inverted in bit 7
  status_bit7_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    msr_rd[0] |=> reg_rdata_o[7] == !$past(port1_modem_i.carrier_n))
    else $error("status bit 7 not the inverse of carrier");
  // port 2 uses the same layout; a slip in the shared mux would swap the ports
  // port 2 set-ready in bit 5
  p2_status_bit5_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    msr_rd[1] |=> reg_rdata_o[5] == !$past(port2_modem_i.set_rdy_n))
    else $error("port 2 status bit 5 not the inverse of set-ready");
  // port 2 clear-to-send in bit 4
  p2_status_bit4_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    msr_rd[1] |=> reg_rdata_o[4] == !$past(port2_modem_i.clr_send_n))
    else $error("port 2 status bit 4 not the inverse of clear-to-send");
  // change flags: a rising pin must be flagged by the next edge
  // the edge history starts inactive, so no flag may appear out of reset
  // port 1 set-ready rise
  dsr_rise_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(port1_modem_i.set_rdy_n) |=> delta_r[0][1])
    else $error("set-ready rise did not set change bit 1");
  // port 1 clear-to-send rise
  cts1_rise_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(port1_modem_i.clr_send_n) |=> delta_r[0][0])
    else $error("port 1 clear-to-send rise did not set change bit 0");
  // port 1 ring rise
  ring_rise_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(port1_modem_i.ring_n) |=> delta_r[0][2])
    else $error("ring rise did not set change bit 2");
  // port 1 carrier rise
  carrier_rise_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(port1_modem_i.carrier_n) |=> delta_r[0][3])
    else $error("carrier rise did not set change bit 3");
  // port 2 set-ready rise
  p2_dsr_rise_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(port2_modem_i.set_rdy_n) |=> delta_r[1][1])
    else $error("port 2 set-ready rise did not set change bit 1");
  // port 2 clear-to-send rise
  cts_rise_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(port2_modem_i.clr_send_n) |=> delta_r[1][0])
    else $error("clear-to-send rise did not set change bit 0");
  // port 2 ring rise
  p2_ring_rise_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(port2_modem_i.ring_n) |=> delta_r[1][2])
    else $error("port 2 ring rise did not set change bit 2");
  // port 2 carrier rise
  p2_carrier_rise_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(port2_modem_i.carrier_n) |=> delta_r[1][3])
    else $error("port 2 carrier rise did not set change bit 3");
  // a falling pin is no low-to-high change, so its flag must not move
  // unless a read clears it in the same cycle
  fall_keeps_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(port1_modem_i.carrier_n) && !msr_rd[0] |=> delta_r[0][3] == $past(delta_r[0][3]))
    else $error("carrier fall changed change bit 3");
  // a read clears the flags unless a rise lands in that very cycle
  // port 1 read clear
  p1_read_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    msr_rd[0] && !(|rise[0]) |=> delta_r[0] == 4'h0)
    else $error("port 1 status read did not clear change flags");
  // port 2 read clear
  read_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    msr_rd[1] && !(|rise[1]) |=> delta_r[1] == 4'h0)
    else $error("status read did not clear change flags");
  // interrupt path
  // port 1 latch stays low while its enable bit is clear
  ms_int_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ier_r[0][MHC_IER_MS_BIT] |=> !port_int_r[0])
    else $error("modem interrupt raised while disabled");
  // port 1 latch rises on any change while enabled, a read in that cycle loses
  ms_int_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ier_r[0][MHC_IER_MS_BIT] && any_chg[0] |=> port_int_r[0])
    else $error("port 1 change with enable set raised no interrupt");
  // port 2 latch stays low while disabled
  p2_int_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !ier_r[1][MHC_IER_MS_BIT] |=> !port_int_r[1])
    else $error("port 2 modem interrupt raised while disabled");
  // port 2 latch rises on any change while enabled
  p2_int_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ier_r[1][MHC_IER_MS_BIT] && any_chg[1] |=> port_int_r[1])
    else $error("port 2 change with enable set raised no interrupt");
  // a new port 2 latch rise is recorded in the sticky status, even against a clear
  sticky_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    int_rise[1] |=> irq_sts_r[1])
    else $error("port 2 interrupt rise lost from sticky status");
  // the level output is the or of enabled status bits
  // both sides are registers loaded at the same edge, so there is no lag
  irq_level_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_o == |(irq_sts_r & irq_en_r))
    else $error("interrupt output disagrees with enabled status");
  // output pins
  // reset leaves port 1 inactive
  reset_high_a: assert property (@(posedge clk_i)
    sys_rst_i |=> port1_req_send_out_n_o && port1_term_ready_out_n_o)
    else $error("outputs not inactive after reset");
  // reset leaves port 2 inactive
  reset_high_p2_a: assert property (@(posedge clk_i)
    sys_rst_i |=> port2_req_send_out_n_o && port2_term_ready_out_n_o)
    else $error("port 2 outputs not inactive after reset");
  // port 1 request-to-send follows a single write two edges later
  rts_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mcr_wr[0] && !reg_req_i.wdata[MHC_MCR_LOOP_BIT] ##1 !mcr_wr[0]
      |=> port1_req_send_out_n_o == !$past(mcr_r[0][MHC_MCR_RTS_BIT]))
    else $error("request-to-send does not follow control bit 1");
  // port 2 request-to-send follows its control bit one edge later
  rts2_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !mcr_r[1][MHC_MCR_LOOP_BIT] |=> port2_req_send_out_n_o == !$past(mcr_r[1][MHC_MCR_RTS_BIT]))
    else $error("port 2 request-to-send does not follow control bit 1");
  // port 1 terminal-ready follows control bit 0
  dtr_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !mcr_r[0][MHC_MCR_LOOP_BIT] |=> port1_term_ready_out_n_o == !$past(mcr_r[0][MHC_MCR_DTR_BIT]))
    else $error("terminal-ready does not follow control bit 0");
  // port 2 terminal-ready follows control bit 0
  dtr2_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !mcr_r[1][MHC_MCR_LOOP_BIT] |=> port2_term_ready_out_n_o == !$past(mcr_r[1][MHC_MCR_DTR_BIT]))
    else $error("port 2 terminal-ready does not follow control bit 0");
  // loop mode wins over the control bits on port 2
  loop_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mcr_r[1][MHC_MCR_LOOP_BIT] |=> port2_req_send_out_n_o && port2_term_ready_out_n_o)
    else $error("outputs driven in loop mode");
  // and on port 1
  p1_loop_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mcr_r[0][MHC_MCR_LOOP_BIT] |=> port1_req_send_out_n_o && port1_term_ready_out_n_o)
    else $error("port 1 outputs driven in loop mode");
  // line path and port separation
  // transmit copy is never gated by clear-to-send
  tx_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> port2_serial_out_o == $past(port2_uart_tx_i))
    else $error("line output is not the transmit bit");
  // receive copy
  rx_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> port2_uart_rx_o == $past(port2_serial_in_i))
    else $error("receive output is not the line input");
  // a port 1 control write must leave port 2 control untouched
  ports_apart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mcr_wr[0] |=> mcr_r[1] == $past(mcr_r[1]))
    else $error("port 1 control write disturbed port 2");
  // scenario covers
  cov_int: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(irq_o));
  cov_loop: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(mcr_r[0][MHC_MCR_LOOP_BIT]));
  cov_clear: cover property (@(posedge clk_i) disable iff (sys_rst_i) msr_rd[0] && |delta_r[0]);
  cov_p2_int: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(port_irq_o));
  cov_sts_clr: cover property (@(posedge clk_i) disable iff (sys_rst_i) clr_wr && |irq_sts_r);
endmodule
`default_nettype wire

// [verification/mhc_modem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// far-side modem: drives the four active-low status lines of both ports
module mhc_modem_model (
  input  wire logic                    clk_i,
  output var  mhc_pkg::mhc_modem_in_t  port1_modem_o,
  output var  mhc_pkg::mhc_modem_in_t  port2_modem_o
);
  import mhc_pkg::*;
  // lines rest inactive (high) until a test moves them
  initial begin
    port1_modem_o = 4'hf;
    port2_modem_o = 4'hf;
  end
  // lag 0 answers at the next edge, a larger lag plays a slow modem
  task automatic drive(input int port, input logic [3:0] val, input int lag);
    repeat (lag) @(posedge clk_i);
    @(posedge clk_i);
    if (port == 1) port1_modem_o <= val;
    else port2_modem_o <= val;
  endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mhc_pkg::*;
  logic          clk_i     = 1'b0;
  logic          sys_rst_i = 1'b1;
  mhc_req_t      req       = '0;   // register port request
  logic          utx       = 1'b1; // uart transmit bit into the block
  logic          srx       = 1'b1; // line receive bit into the block
  logic          rd_d      = 1'b0; // read taken one edge ago
  logic [7:0]    rdata;
  mhc_modem_in_t m1, m2;
  logic          rts1, dtr1, rts2, dtr2, ser_o, urx_o, pirq, irq;
  logic [7:0]    exp_q[$];         // expected read data, oldest first
  logic [3:0]    r;
  logic [1:0]    c1;
  int            bad_count = 0;
  int            compares  = 0;
  int            cycles    = 0;
  always #5 clk_i = ~clk_i;
  mhc_top u_mhc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .port1_modem_i(m1), .port2_modem_i(m2), .port1_req_send_out_n_o(rts1),
    .port1_term_ready_out_n_o(dtr1), .port2_req_send_out_n_o(rts2), .port2_term_ready_out_n_o(dtr2),
    .port2_uart_tx_i(utx), .port2_serial_in_i(srx), .port2_serial_out_o(ser_o),
    .port2_uart_rx_o(urx_o), .port_irq_o(pirq), .irq_o(irq));
  mhc_modem_model u_mhc_modem_model (.clk_i(clk_i), .port1_modem_o(m1), .port2_modem_o(m2));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one idle cycle after each strobe keeps every nba to req in its own step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req <= '0;
    @(posedge clk_i);
  endtask
  // read data stand only in the cycle after the strobe, so look exactly there
  always @(posedge clk_i) begin
    rd_d <= req.rd;
    if (rd_d) check("rdata", exp_q.pop_front(), rdata);
  end
  // hang guard, far above the 130 or so cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      check("timeout", 8'h00, 8'h01);
      finish_test();
    end
  end
  initial begin
    void'($urandom(97932));
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset outs", 8'h0f, {4'h0, rts1, dtr1, rts2, dtr2});
    // every code of control bits 0 and 1, ports set opposite to show they are independent
    for (int v = 0; v < 4; v++) begin
      c1 = 2'(v);
      wr(MHC_P1_MCR_OFF, {6'h00, c1});
      wr(MHC_P2_MCR_OFF, {6'h00, ~c1});
      @(posedge clk_i);
      check("ctrl outs", {4'h0, ~c1, c1}, {4'h0, rts1, dtr1, rts2, dtr2});
    end
    wr(MHC_P1_MCR_OFF, 8'h13);
    wr(MHC_P2_MCR_OFF, 8'h03);
    @(posedge clk_i);
    check("loop outs", 8'h0c, {4'h0, rts1, dtr1, rts2, dtr2});
    rd(MHC_P1_MCR_OFF, 8'h13);
    rd(MHC_P2_MCR_OFF, 8'h03);
    // falling lines set no change flag; rising ones do, read clears them
    u_mhc_modem_model.drive(1, 4'h0, 0);
    repeat (3) @(posedge clk_i);
    rd(MHC_P1_MSR_OFF, 8'hf0);
    u_mhc_modem_model.drive(1, 4'hf, 5);
    repeat (3) @(posedge clk_i);
    rd(MHC_P1_MSR_OFF, 8'h0f);
    rd(MHC_P1_MSR_OFF, 8'h00);
    r = 4'($urandom);
    u_mhc_modem_model.drive(2, r, 0);
    repeat (3) @(posedge clk_i);
    rd(MHC_P2_MSR_OFF, {~r, 4'h0});
    u_mhc_modem_model.drive(2, 4'hf, 2);
    repeat (3) @(posedge clk_i);
    rd(MHC_P2_MSR_OFF, {4'h0, ~r});
    // serial path follows its own bits whatever port 1 clear-to-send does
    for (int k = 0; k < 2; k++) begin
      utx <= k[0];
      srx <= ~k[0];
      u_mhc_modem_model.drive(1, {3'b111, k[0]}, 0);
      repeat (3) @(posedge clk_i);
      check("serial", {6'h00, k[0], ~k[0]}, {6'h00, ser_o, urx_o});
    end
    rd(MHC_P1_MSR_OFF, 8'h01);
    // a change with the enable bit clear must stay silent
    u_mhc_modem_model.drive(1, 4'h7, 0);
    repeat (4) @(posedge clk_i);
    check("irq masked", 8'h00, {7'h00, irq});
    wr(MHC_P1_IER_OFF, 8'h08);
    wr(MHC_IRQ_EN_OFF, 8'h03);
    u_mhc_modem_model.drive(1, 4'hf, 0);
    repeat (4) @(posedge clk_i);
    check("irq raised", 8'h01, {7'h00, irq});
    rd(MHC_P1_MSR_OFF, 8'h08);
    wr(MHC_IRQ_CLR_OFF, 8'h01);
    repeat (2) @(posedge clk_i);
    check("irq cleared", 8'h00, {7'h00, irq});
    wr(MHC_P2_IER_OFF, 8'h08);
    u_mhc_modem_model.drive(2, 4'he, 0);
    repeat (4) @(posedge clk_i);
    check("port2 irq", 8'h03, {6'h00, pirq, irq});
    rd(MHC_IRQ_STS_OFF, 8'h02);
    rd(MHC_IRQ_EN_OFF, 8'h03);
    rd(MHC_P2_IER_OFF, 8'h08);
    rd(8'h3c, 8'h00);
    wr(MHC_P1_MSR_OFF, 8'hff);
    rd(MHC_P1_MSR_OFF, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
